// *** adc_seq_pkg.sv ***
package adc_seq_pkg;

  // Register indices on the plain register port
  localparam logic [4:0] REG_CON1 = 5'h00;
  localparam logic [4:0] REG_CON2 = 5'h01;
  localparam logic [4:0] REG_CON3 = 5'h02;
  localparam logic [4:0] REG_CHSEL = 5'h03;
  localparam logic [4:0] REG_PCFGL = 5'h04;
  localparam logic [4:0] REG_PCFGH = 5'h05;
  localparam logic [4:0] REG_IRQ_STAT = 5'h06;
  localparam logic [4:0] REG_IRQ_MASK = 5'h07;
  localparam logic [4:0] REG_BUF0 = 5'h10;

  // Field positions
  localparam int ON_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int AUTO_SAMPLE_START_BIT = 2;
  localparam int SAMPLE_ACTIVE_BIT = 1;
  localparam int DONE_BIT = 0;
  localparam int BUFFER_HALF_STATUS_BIT = 7;
  localparam int SPLIT_BUFFER_MODE_BIT = 1;

  // Writable masks of the control registers
  localparam logic [15:0] CON1_WMASK = 16'hA3E6;
  localparam logic [15:0] CON2_WMASK = 16'hE43F;
  localparam logic [15:0] CON3_WMASK = 16'hDFFF;
  localparam logic [15:0] RESET_VAL = 16'h0000;

  // Trigger sources
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_PIN = 3'h1;
  localparam logic [2:0] TRIG_AUTO = 3'h7;

  localparam int RES_BITS = 10;
  localparam int CONV_TAD = 12;

  // Result formats
  localparam logic [1:0] FMT_INT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;

  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BATCH = 1;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_STORE = 4'b1000
  } seq_state_t;

endpackage : adc_seq_pkg

// *** adc_clk_div.sv ***
`timescale 1ns/1ps
// Conversion clock tick generator from the system clock
module adc_clk_div
  import adc_seq_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic run, // Divider runs while high
  input wire logic [7:0] div_sel, // Period is div_sel+1 clocks
  output logic tick // One-cycle pulse per conversion clock
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q, s_d;

  // Count down and pulse on wrap
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = div_sel;
    end else if (s_q.cnt == 8'h00) begin
      s_d.cnt = div_sel;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : adc_clk_div

// *** adc_seq_ctrl.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Converter control and sequencer: registers, sequence, result buffer
module adc_seq_ctrl
  import adc_seq_pkg::*;
#(
  parameter int NUM_CH = 13, // Analog inputs
  parameter int BUF_WORDS = 16 // Result buffer depth
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic [4:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire logic trig_pin, // External trigger pin, async
  input wire logic cpu_idle, // Processor idle request
  input wire logic [9:0] conv_code, // Code from the analog comparator path
  output logic [3:0] ch_sel, // Selected analog channel
  output logic sample_en, // Sample/hold amplifier sampling
  output logic conv_start, // Pulse: conversion starts
  output logic [2:0] vref_sel, // Reference source select
  output logic [15:0] pin_analog, // Pin analog marks
  output logic [1:0] bandgap_sel, // Band gap reference inputs
  output logic irq // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] con3;
    logic [3:0] chsel;
    logic [15:0] pcfgl;
    logic [1:0] pcfgh;
    logic [1:0] istat;
    logic [1:0] imask;
    seq_state_t st;
    logic [4:0] cnt;
    logic [3:0] widx;
    logic [3:0] nconv;
    logic [2:0] trig_sync;
    logic trig_lvl;
    logic conv_start;
    logic [15:0] rdata;
  } state_t;

  state_t s_q, s_d;
  logic [15:0] buf_q [BUF_WORDS];
  logic tad_tick;
  logic trig_event;
  logic wr_buf;
  logic [15:0] buf_word;
  logic on;
  logic halted;
  logic [1:0] irq_set; // Status bits set by hardware this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Arrange a 10-bit code in the chosen format
  function automatic logic [15:0] fmt_word(input logic [1:0] fmt, input logic [9:0] c);
    logic [9:0] sc;
    sc = {~c[9], c[8:0]};
    case (fmt)
      FMT_INT: fmt_word = {6'h00, c};
      FMT_SINT: fmt_word = {{6{sc[9]}}, sc};
      FMT_FRAC: fmt_word = {c, 6'h00};
      FMT_SFRAC: fmt_word = {sc, 6'h00};
      default: fmt_word = 16'h0000;
    endcase
  endfunction : fmt_word

  // Mask a write into writable bits
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [15:0] m);
    wmerge = (old & ~m) | (nw & m);
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock

  assign on = s_q.con1[ON_BIT];
  // Idle halt only stops new sequences, keeps registers
  assign halted = s_q.con1[IDLE_BIT] & cpu_idle;

  adc_clk_div u_div (
    .clk(clk),
    .arst_n(arst_n),
    .run(on),
    .div_sel(s_q.con3[7:0]),
    .tick(tad_tick)
  );

  // Trigger pin edge once the last two stages agree
  assign trig_event = (s_q.trig_sync[2] == s_q.trig_sync[1]) && s_q.trig_sync[1] &&
                      !s_q.trig_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    wr_buf = 1'b0;
    irq_set = 2'b00;
    buf_word = fmt_word(s_q.con1[9:8], conv_code);
    s_d.conv_start = 1'b0;
    s_d.trig_sync = {s_q.trig_sync[1:0], trig_pin};
    if (s_q.trig_sync[2] == s_q.trig_sync[1]) begin
      s_d.trig_lvl = s_q.trig_sync[1];
    end
    s_d.rdata = 16'h0000;

    // Sequencer
    case (s_q.st)
      ST_IDLE: begin
        if (on && !halted && (s_q.con1[AUTO_SAMPLE_START_BIT] || s_q.con1[SAMPLE_ACTIVE_BIT])) begin
          s_d.st = ST_SAMPLE;
          s_d.con1[SAMPLE_ACTIVE_BIT] = 1'b1;
          s_d.cnt = 5'h00;
        end
      end
      ST_SAMPLE: begin
        // Trigger choice with sample time
        case (s_q.con1[7:5])
          TRIG_MANUAL: begin
            if (!s_q.con1[SAMPLE_ACTIVE_BIT]) begin
              s_d.st = ST_CONVERT;
            end
          end
          TRIG_PIN: begin
            if (trig_event) begin
              s_d.st = ST_CONVERT;
            end
          end
          TRIG_AUTO: begin
            if (tad_tick) begin
              s_d.cnt = s_q.cnt + 5'h01;
              if (s_q.cnt >= s_q.con3[12:8]) begin
                s_d.st = ST_CONVERT;
              end
            end
          end
          default: begin
            // Unimplemented sources: held until sample bit clears
            if (!s_q.con1[SAMPLE_ACTIVE_BIT]) begin
              s_d.st = ST_CONVERT;
            end
          end
        endcase
        if (s_d.st == ST_CONVERT) begin
          s_d.con1[SAMPLE_ACTIVE_BIT] = 1'b0;
          s_d.con1[DONE_BIT] = 1'b0;
          s_d.conv_start = 1'b1;
          s_d.cnt = 5'h00;
        end
      end
      ST_CONVERT: begin
        if (tad_tick) begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'(CONV_TAD - 1)) begin
            s_d.st = ST_STORE;
          end
        end
      end
      ST_STORE: begin
        wr_buf = 1'b1;
        s_d.con1[DONE_BIT] = 1'b1;
        s_d.istat[IRQ_DONE] = 1'b1;
        irq_set[IRQ_DONE] = 1'b1;
        s_d.widx = s_q.widx + 4'h1;
        s_d.nconv = s_q.nconv + 4'h1;
        if (s_q.nconv == s_q.con2[5:2]) begin
          // Batch of conversions complete
          s_d.istat[IRQ_BATCH] = 1'b1;
          irq_set[IRQ_BATCH] = 1'b1;
          s_d.nconv = 4'h0;
          if (s_q.con2[SPLIT_BUFFER_MODE_BIT]) begin
            s_d.con2[BUFFER_HALF_STATUS_BIT] = ~s_q.con2[BUFFER_HALF_STATUS_BIT];
            s_d.widx = s_q.con2[BUFFER_HALF_STATUS_BIT] ? 4'h0 : 4'h8;
          end else begin
            s_d.widx = 4'h0;
          end
        end
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Register writes; hardware sets beat software clears for the done bit and the interrupt status bits only
    if (reg_wr) begin
      case (reg_addr)
        REG_CON1: begin
          s_d.con1 = wmerge(s_d.con1, reg_wdata, CON1_WMASK);
          if (!reg_wdata[DONE_BIT] && !(s_q.st == ST_STORE)) begin
            s_d.con1[DONE_BIT] = 1'b0;
          end
        end
        REG_CON2: s_d.con2 = wmerge(s_q.con2, reg_wdata, CON2_WMASK);
        REG_CON3: s_d.con3 = wmerge(s_q.con3, reg_wdata, CON3_WMASK);
        REG_CHSEL: begin
          if (reg_wdata[3:0] < 4'(NUM_CH)) begin
            s_d.chsel = reg_wdata[3:0];
          end
        end
        REG_PCFGL: s_d.pcfgl = reg_wdata;
        REG_PCFGH: s_d.pcfgh = reg_wdata[1:0];
        // Write one clears; a set in the same cycle wins
        REG_IRQ_STAT: s_d.istat = (s_q.istat & ~reg_wdata[1:0]) | irq_set;
        REG_IRQ_MASK: s_d.imask = reg_wdata[1:0];
        default: ;
      endcase
    end

    // Turning off aborts sequencing and resets buffer pointers
    if (!s_d.con1[ON_BIT]) begin
      s_d.st = ST_IDLE;
      s_d.con1[SAMPLE_ACTIVE_BIT] = 1'b0;
      s_d.conv_start = 1'b0; // No start pulse escapes a switch-off
      s_d.widx = 4'h0;
      s_d.nconv = 4'h0;
      s_d.con2[BUFFER_HALF_STATUS_BIT] = 1'b0;
    end

    // Read mux
    if (reg_rd) begin
      case (reg_addr)
        REG_CON1: s_d.rdata = s_q.con1;
        REG_CON2: s_d.rdata = s_q.con2;
        REG_CON3: s_d.rdata = s_q.con3;
        REG_CHSEL: s_d.rdata = {12'h000, s_q.chsel};
        REG_PCFGL: s_d.rdata = s_q.pcfgl;
        REG_PCFGH: s_d.rdata = {14'h0000, s_q.pcfgh};
        REG_IRQ_STAT: s_d.rdata = {14'h0000, s_q.istat};
        REG_IRQ_MASK: s_d.rdata = {14'h0000, s_q.imask};
        default: begin
          if (reg_addr[4]) begin
            s_d.rdata = buf_q[reg_addr[3:0]];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Result buffer; cleared while off so nothing survives a disable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_q[i] <= 16'h0000;
      end
    end else if (!on) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_q[i] <= 16'h0000;
      end
    end else if (wr_buf) begin
      buf_q[s_q.widx] <= buf_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = s_q.rdata;
  assign ch_sel = s_q.chsel;
  assign sample_en = s_q.st == ST_SAMPLE;
  assign conv_start = s_q.conv_start;
  assign vref_sel = s_q.con2[15:13];
  assign pin_analog = s_q.pcfgl;
  assign bandgap_sel = s_q.pcfgh;
  // Level interrupt from unmasked sticky bits
  assign irq = |(s_q.istat & s_q.imask);

endmodule : adc_seq_ctrl

// *** adc_seq_monitor.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port-level checks of the converter sequencer
module adc_seq_monitor
  import adc_seq_pkg::*;
#(
  parameter int NUM_CH = 13, // Analog inputs
  parameter int BUF_WORDS = 16 // Buffer depth
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, low
  input wire logic [4:0] reg_addr, // Index
  input wire logic [15:0] reg_wdata, // Data
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic trig_pin, // Trigger
  input wire logic cpu_idle, // Idle
  input wire logic [9:0] conv_code, // Code
  input wire logic [3:0] ch_sel, // Channel
  input wire logic sample_en, // Sampling
  input wire logic conv_start, // Start
  input wire logic [2:0] vref_sel, // Reference
  input wire logic [15:0] pin_analog, // Pin marks
  input wire logic [1:0] bandgap_sel, // Band gap
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Register writes and the quiet front end after switch-off
  sequence s_wr(logic [4:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_off;
    s_wr(REG_CON1) ##0 !reg_wdata[ON_BIT];
  endsequence
  sequence s_quiet;
    (!sample_en && !conv_start) [*4];
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr inside {[5'h08:5'h0F]} |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_vref_load: assert property (s_wr(REG_CON2) |=> vref_sel == $past(reg_wdata[15:13]))
    else $error("reference select not loaded");
  a_pin_load: assert property (s_wr(REG_PCFGL) |=> pin_analog == $past(reg_wdata))
    else $error("pin marks not loaded");
  a_bandgap_load: assert property (s_wr(REG_PCFGH) |=> bandgap_sel == $past(reg_wdata[1:0]))
    else $error("band gap select not loaded");
  a_chsel_range: assert property (ch_sel < NUM_CH)
    else $error("channel out of range");
  a_chsel_load: assert property (s_wr(REG_CHSEL) ##0 reg_wdata < NUM_CH |=> ch_sel == $past(reg_wdata[3:0]))
    else $error("channel not loaded");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_off_quiet: assert property (s_off |=> ##1 s_quiet)
    else $error("front end active while off");
endmodule : adc_seq_monitor

// *** adc_front_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Analog front end: a code per conversion, garbage while sampling
module adc_front_model (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, low
  input wire logic conv_start, // Start pulse
  input wire logic sample_en, // Sampling
  output logic [9:0] conv_code // Code
);
  logic [9:0] code_q;
  logic odd_q;
  // Alternate codes so both sign halves are seen; invert while not valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= 10'h000;
      odd_q <= 1'b0;
    end else if (conv_start) begin
      code_q <= odd_q ? 10'h15A : 10'h2A5;
      odd_q <= ~odd_q;
    end
  end
  assign conv_code = sample_en ? ~code_q : code_q;
endmodule : adc_front_model

// *** tb_top.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top
  import adc_seq_pkg::*;
;
  logic clk, arst_n, reg_wr, reg_rd, trig_pin, cpu_idle, sample_en, conv_start, irq;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pin_analog, v;
  logic [9:0] conv_code;
  logic [3:0] ch_sel;
  logic [2:0] vref_sel;
  logic [1:0] bandgap_sel;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  adc_seq_ctrl DUT (.*);
  adc_front_model front (.clk(clk), .arst_n(arst_n), .conv_start(conv_start),
    .sample_en(sample_en), .conv_code(conv_code));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1; // Outputs launched by this edge are settled before any compare
  endtask : wr
  // Read data stands only in the cycle after the strobe edge
  task rd(input logic [4:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task rd_chk(input logic [4:0] a, input logic [15:0] exp);
    rd(a);
    check(v, exp);
  endtask : rd_chk
  // Result layout per format for a ten-bit code
  function automatic logic [15:0] fmt(input logic [1:0] f, input logic [9:0] c);
    logic [9:0] s;
    s = c ^ 10'h200;
    case (f)
      FMT_INT: return {6'h00, c};
      FMT_SINT: return {{6{s[9]}}, s};
      FMT_FRAC: return {c, 6'h00};
      default: return {s, 6'h00};
    endcase
  endfunction : fmt
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, reg_wr, reg_rd, trig_pin, cpu_idle} = 5'h00;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 6; a++) rd_chk(a[4:0], RESET_VAL);
    check({15'h0000, irq}, 16'h0000);
    rd_chk(5'h08, 16'h0000);
    // Sample bit cannot stand while the converter is off
    wr(REG_CON1, 16'h7FFF);
    rd_chk(REG_CON1, 16'h23E4);
    wr(REG_CON1, 16'h0000);
    // Configuration in the recommended order, enable last
    wr(REG_PCFGL, 16'hFFFF);
    wr(REG_PCFGH, 16'h0003);
    check(pin_analog, 16'hFFFF);
    check({14'h0000, bandgap_sel}, 16'h0003);
    wr(REG_CON2, 16'hFFFF);
    rd_chk(REG_CON2, 16'hE43F);
    check({13'h0000, vref_sel}, 16'h0007);
    wr(REG_CON2, 16'h000C);
    wr(REG_CON3, 16'hFFFF);
    rd_chk(REG_CON3, 16'hDFFF);
    wr(REG_CON3, 16'h0001);
    wr(REG_CHSEL, 16'h000C);
    wr(REG_CHSEL, 16'h000D);
    check({12'h000, ch_sel}, 16'h000C);
    wr(REG_CHSEL, 16'h0005);
    wr(REG_IRQ_STAT, 16'h0003);
    wr(REG_IRQ_MASK, 16'h0000);
    // Four manual conversions, one per format, batch of four
    for (int k = 0; k < 4; k++) begin
      wr(REG_CON1, 16'h8002 | (k << 8));
      wr(REG_CON1, 16'h8000 | (k << 8));
      for (int n = 0; n < 100; n++) begin
        rd(REG_CON1);
        if (v[DONE_BIT] === 1'b1) break;
      end
      check(v, 16'h8001 | (k << 8));
      rd_chk(REG_BUF0 + k[4:0], fmt(k[1:0], k[0] ? 10'h15A : 10'h2A5));
    end
    rd_chk(REG_IRQ_STAT, 16'h0003);
    check({15'h0000, irq}, 16'h0000);
    wr(REG_IRQ_MASK, 16'h0003);
    check({15'h0000, irq}, 16'h0001);
    wr(REG_IRQ_STAT, 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    wr(REG_IRQ_STAT, 16'h0002);
    check({15'h0000, irq}, 16'h0000);
    wr(REG_CON1, 16'h8300);
    rd_chk(REG_CON1, 16'h8300);
    // Pin trigger ends sampling; result lands in word zero
    wr(REG_CON1, 16'h8022);
    repeat (4) @(posedge clk);
    trig_pin <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      rd(REG_CON1);
      if (v[DONE_BIT] === 1'b1) break;
    end
    trig_pin <= 1'b0;
    check(v, 16'h8021);
    rd_chk(REG_BUF0, 16'h02A5);
    wr(REG_CON1, 16'h0000);
    rd_chk(REG_BUF0, 16'h0000);
    finish_test();
  end
endmodule : tb_top

bind adc_seq_ctrl adc_seq_monitor #(.NUM_CH(NUM_CH), .BUF_WORDS(BUF_WORDS)) mon (.*);
